/* File: logic/oad_pkg.sv */
`default_nettype none
package oad_pkg;
  // ==========================================================
  // register file layout of this bus slave
  localparam logic [11:0] OAD_OFF_INSN = 12'h000;
  localparam logic [11:0] OAD_OFF_REGS = 12'h004;
  localparam logic [11:0] OAD_OFF_SEGS = 12'h008;
  localparam logic [11:0] OAD_OFF_ADDR = 12'h00C;
  localparam logic [11:0] OAD_OFF_FLAGW = 12'h010;
  localparam logic [11:0] OAD_OFF_STAT = 12'h014;
  localparam logic [11:0] OAD_OFF_GPR_BASE = 12'h020;
  localparam logic [15:0] OAD_FLAG_RESET = 16'h0000;
  localparam logic [15:0] OAD_FLAG_MASK = 16'h0FD5;
  localparam int OAD_POS_CARRY = 0;
  localparam int OAD_POS_PARITY = 2;
  localparam int OAD_POS_AUX = 4;
  localparam int OAD_POS_ZERO = 6;
  localparam int OAD_POS_SIGN = 7;
  localparam int OAD_POS_TRACE = 8;
  localparam int OAD_POS_INTEN = 9;
  localparam int OAD_POS_DIR = 10;
  localparam int OAD_POS_OVER = 11;
  // addressing-kind encodings
  localparam logic [1:0] OAD_KIND_NODISP = 2'b00;
  localparam logic [1:0] OAD_KIND_DISP8 = 2'b01;
  localparam logic [1:0] OAD_KIND_DISP16 = 2'b10;
  localparam logic [1:0] OAD_KIND_REG = 2'b11;
  localparam logic [2:0] OAD_RM_DIRECT = 3'b110;
  localparam logic [1:0] OAD_SEG_CODE = 2'b01;
  // ==========================================================
  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] kind;
    logic [2:0] sel;
    logic [2:0] rm;
    logic [7:0] disp_lo;
    logic [7:0] disp_hi;
  } oad_insn_type;
  typedef struct packed {
    logic mem_op;
    logic [2:0] reg_sel;
    logic [2:0] rm_reg_sel;
    logic [1:0] seg_sel;
    logic seg_load_bad;
    logic [15:0] effective_address;
    logic [2:0] disp_bytes;
  } oad_result_type;
  typedef enum logic [2:0]
  {
    OAD_ST_IDLE = 3'b001,
    OAD_ST_EVAL = 3'b010,
    OAD_ST_DONE = 3'b100
  } oad_state_type;
endpackage : oad_pkg
`default_nettype wire

/* File: logic/oad_reg_pick.sv */
`default_nettype none
// ==========================================================
// operand-select decode: word register or byte half
module oad_reg_pick
  import oad_pkg::*;
(
  input wire logic [2:0] sel,
  input wire logic word_op,
  input wire logic [15:0] gpr [8],
  output logic [15:0] value
);
  wire [15:0] byte_src = gpr[{1'b0, sel[1:0]}];
  wire [7:0] byte_val = sel[2] ? byte_src[15:8] : byte_src[7:0];
  // size bit 1 picks a word, 0 a low/high byte half
  assign value = word_op ? gpr[sel] : {8'h00, byte_val};
endmodule : oad_reg_pick
`default_nettype wire

/* File: logic/oad_top.sv */
// Summary of operation
// - rm 000..011: address is base/bp plus si/di plus displacement.
// - rm 100..111: address is si, di, bp or base plus displacement.
// - kind 00 with rm 110: address is the 16-bit direct displacement.
// - displacement bytes follow byte two; immediate data follows displacement.
// - move into the code segment is flagged invalid, never loaded.
// - condition word: flags at bits 0,2,4,6..11; other bits read zero.
// - select field picks eight word registers, or byte halves of first four.
// - kind 11: rm field selects a register, no address formed.
// - kind 00 no disp, 01 sign-extended byte, 10 word low first.
// - size bit 1 means word operation, 0 means byte.
`default_nettype none
module oad_top
  import oad_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // ==========================================================
  // register state
  oad_insn_type insn_q;
  logic word_op_q;
  logic [15:0] gpr_q [8];
  logic [15:0] flags_q;
  oad_result_type res_q;
  logic [15:0] reg_val_q, rm_val_q;
  oad_state_type state_q, state_d;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // ==========================================================
  // bus decode
  wire access = PSEL && PENABLE && CLK_EN;
  wire wr = access && PWRITE;
  wire rd = access && !PWRITE;
  wire hit_insn = PADDR == OAD_OFF_INSN;
  wire hit_regs = PADDR == OAD_OFF_REGS;
  wire hit_segs = PADDR == OAD_OFF_SEGS;
  wire hit_addr = PADDR == OAD_OFF_ADDR;
  wire hit_flag = PADDR == OAD_OFF_FLAGW;
  wire hit_stat = PADDR == OAD_OFF_STAT;
  wire hit_gpr = PADDR[11:5] == OAD_OFF_GPR_BASE[11:5] && PADDR[1:0] == 2'b00;
  wire [2:0] gpr_idx = PADDR[4:2];
  wire mapped = hit_insn | hit_regs | hit_segs | hit_addr | hit_flag | hit_stat | hit_gpr;

  // ==========================================================
  // operand decode, all combinational from the latched instruction
  wire [1:0] kind = insn_q.kind;
  wire [2:0] rm = insn_q.rm;
  wire direct = kind == OAD_KIND_NODISP && rm == OAD_RM_DIRECT;
  wire [15:0] disp16 = {insn_q.disp_hi, insn_q.disp_lo};
  wire [15:0] disp8x = {{8{insn_q.disp_lo[7]}}, insn_q.disp_lo};
  // displacement chosen by kind; high byte ignored unless kind is 10 or the form is direct (kind 00, rm 110)
  wire [15:0] disp = kind == OAD_KIND_DISP8 ? disp8x :
                     kind == OAD_KIND_DISP16 ? disp16 : 16'h0000;
  // base term: rm[1] picks bp over the base register for pairs
  wire [15:0] pair_base = rm[1] ? gpr_q[5] : gpr_q[3];
  wire [15:0] pair_index = rm[0] ? gpr_q[7] : gpr_q[6];
  // single-register forms: si, di, bp, base in that order
  wire [15:0] single = rm[1:0] == 2'b00 ? gpr_q[6] :
                       rm[1:0] == 2'b01 ? gpr_q[7] :
                       rm[1:0] == 2'b10 ? gpr_q[5] : gpr_q[3];
  wire [15:0] effective_address = direct ? disp16 :
                                  rm[2] ? single + disp :
                                  pair_base + pair_index + disp;
  // byte count after the second instruction byte, before immediates
  wire [2:0] disp_bytes = direct || kind == OAD_KIND_DISP16 ? 3'd2 :
                          kind == OAD_KIND_DISP8 ? 3'd1 : 3'd0;
  wire mem_op = kind != OAD_KIND_REG;
  wire [1:0] seg_sel = insn_q.sel[1:0];
  // a segment move into code segment is refused; the load never happens
  wire seg_move = insn_q.opcode == 8'h8E;
  wire seg_load_bad = seg_move && seg_sel == OAD_SEG_CODE;
  wire word_op = word_op_q;
  logic [15:0] reg_val, rm_val;

  oad_reg_pick u_sel
  (
    .sel(insn_q.sel),
    .word_op(word_op),
    .gpr(gpr_q),
    .value(reg_val)
  );
  oad_reg_pick u_rm
  (
    .sel(rm),
    .word_op(word_op),
    .gpr(gpr_q),
    .value(rm_val)
  );

  // ==========================================================
  // sequencer: a write to the instruction word starts one evaluation
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      OAD_ST_IDLE: if (wr && hit_insn) state_d = OAD_ST_EVAL;
      OAD_ST_EVAL: state_d = OAD_ST_DONE;
      OAD_ST_DONE: if (wr && hit_insn) state_d = OAD_ST_EVAL;
      default: state_d = OAD_ST_IDLE;
    endcase
  end

  // ==========================================================
  // software writes; gpr writes mid-evaluation are taken but results
  // capture the values present in the eval cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      insn_q <= '0;
      word_op_q <= 1'b0;
      flags_q <= OAD_FLAG_RESET;
      state_q <= OAD_ST_IDLE;
      for (int i = 0; i < 8; i++) gpr_q[i] <= 16'h0000;
    end
    else if (CLK_EN)
    begin
      state_q <= state_d;
      if (wr && hit_insn)
      begin
        insn_q.opcode <= PWDATA[7:0];
        word_op_q <= PWDATA[0];
        insn_q.kind <= PWDATA[15:14];
        insn_q.sel <= PWDATA[13:11];
        insn_q.rm <= PWDATA[10:8];
        insn_q.disp_lo <= PWDATA[23:16];
        insn_q.disp_hi <= PWDATA[31:24];
      end
      if (wr && hit_flag) flags_q <= PWDATA[15:0] & OAD_FLAG_MASK;
      if (wr && hit_gpr) gpr_q[gpr_idx] <= PWDATA[15:0];
    end
  end

  // ==========================================================
  // result capture in the evaluation cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      res_q <= '0;
      reg_val_q <= 16'h0000;
      rm_val_q <= 16'h0000;
    end
    else if (CLK_EN && state_q == OAD_ST_EVAL)
    begin
      res_q.mem_op <= mem_op;
      res_q.reg_sel <= insn_q.sel;
      res_q.rm_reg_sel <= mem_op ? 3'd0 : rm;
      res_q.seg_sel <= seg_sel;
      res_q.seg_load_bad <= seg_load_bad;
      res_q.effective_address <= mem_op ? effective_address : 16'h0000;
      res_q.disp_bytes <= mem_op ? disp_bytes : 3'd0;
      reg_val_q <= reg_val;
      rm_val_q <= rm_val;
    end
  end

  // ==========================================================
  // read mux; unmapped addresses answer zero with an error
  wire [31:0] rd_mux =
    hit_insn ? {insn_q.disp_hi, insn_q.disp_lo, insn_q.kind, insn_q.sel, insn_q.rm,
                insn_q.opcode} :
    hit_regs ? {rm_val_q, reg_val_q} :
    hit_segs ? {26'h0, res_q.seg_load_bad, res_q.rm_reg_sel, res_q.seg_sel} :
    hit_addr ? {13'h0, res_q.disp_bytes, res_q.effective_address} :
    hit_flag ? {16'h0000, flags_q} :
    hit_stat ? {27'h0, res_q.mem_op, 1'b0, state_q[0], state_q[1], state_q[2]} :
    hit_gpr ? {16'h0000, gpr_q[gpr_idx]} : 32'h0000_0000;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      prdata_q <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : prdata_q;
      pslverr_q <= PSEL && !PENABLE && !mapped;
    end
  end

  // zero-wait answer: data set up in the setup cycle, ready in access
  assign PREADY = PSEL && PENABLE && CLK_EN;
  assign PRDATA = rd ? prdata_q : 32'h0000_0000;
  assign PSLVERR = access && pslverr_q;
endmodule : oad_top
`default_nettype wire

/* File: bench/oad_chk.sv */
`default_nettype none
module oad_chk
  import oad_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  logic [31:0] insn_q;
  logic [2:0] age_q;
  wire logic [1:0] kind = insn_q[15:14];
  wire logic direct = kind == 2'b00 && insn_q[10:8] == 3'b110;
  wire logic [2:0] exp_disp = (kind == 2'b01) ? 3'd1 : (kind == 2'b10 || direct) ? 3'd2 : 3'd0;
  // ==========================================================
  // last instruction and its age; results need a few edges to settle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N || (PSEL && PENABLE && PWRITE && CLK_EN && PADDR == OAD_OFF_INSN))
    begin
      insn_q <= RESET_N ? PWDATA : 32'h00000000;
      age_q <= 3'd0;
    end
    else if (age_q != 3'd7)
      age_q <= age_q + 3'd1;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  sequence rd_s(logic [11:0] a);
    PSEL && PENABLE && !PWRITE && CLK_EN && PADDR == a;
  endsequence
  sequence res_s(logic [11:0] a);
    rd_s(a) ##0 age_q >= 3'd3;
  endsequence
  flag_mask_a: assert property (rd_s(OAD_OFF_FLAGW) |-> (PRDATA & ~32'h0FD5) == 0)
    else $error("reserved flag bits set");
  ready_zero_a: assert property (PSEL && !PENABLE && CLK_EN ##1 PENABLE && CLK_EN |-> PREADY)
    else $error("access not answered");
  err_unmapped_a: assert property (PSEL && PENABLE && CLK_EN && PADDR > 12'h03C |-> PSLVERR)
    else $error("unmapped access without error");
  reg_no_ea_a: assert property (res_s(OAD_OFF_ADDR) ##0 kind == 2'b11 |-> PRDATA[15:0] == 0)
    else $error("address formed for register operand");
  direct_ea_a: assert property (res_s(OAD_OFF_ADDR) ##0 direct |-> PRDATA[15:0] == insn_q[31:16])
    else $error("direct address wrong");
  disp_count_a: assert property (res_s(OAD_OFF_ADDR) |-> PRDATA[18:16] == exp_disp)
    else $error("displacement byte count wrong");
  code_seg_a: assert property (res_s(OAD_OFF_SEGS) ##0 insn_q[7:0] != 8'h8E |-> !PRDATA[5])
    else $error("segment load refused wrongly");
  stat_done_a: assert property (res_s(OAD_OFF_STAT) |-> PRDATA[0] && !PRDATA[1])
    else $error("decode not done");
endmodule : oad_chk
bind oad_top oad_chk u_oad_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

/* File: bench/oad_apb_master.sv */
`default_nettype none
module oad_apb_master
(
  input wire logic clk_sys,
  output var logic psel = 1'b0,
  output var logic penable = 1'b0,
  output var logic pwrite = 1'b0,
  output var logic [11:0] paddr = 12'h000,
  output var logic [31:0] pwdata = 32'h00000000,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // one transfer; request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // stale data must not look valid
  endtask : xfer
endmodule : oad_apb_master
`default_nettype wire

/* File: bench/oad_top_test.sv */
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module oad_top_test
  import oad_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] r, s, a;
  logic e;
  oad_top u_oad_top (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(clk_en), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  oad_apb_master u_oad_apb_master (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  always #2.5 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  function automatic logic [15:0] gv(input int i);
    return 16'h1357 + 16'(i) * 16'h1111;
  endfunction : gv
  task automatic xf(input logic w, input logic [11:0] ad, input logic [31:0] d);
    u_oad_apb_master.xfer(w, ad, d, r, e);
  endtask : xf
  // decode waits out the two-edge evaluation before reading results
  task automatic dec(input logic [31:0] ins);
    xf(1'b1, OAD_OFF_INSN, ins);
    repeat (4) @(posedge clk_sys);
    xf(1'b0, OAD_OFF_SEGS, 0);
    s = r;
    xf(1'b0, OAD_OFF_ADDR, 0);
    a = r;
    xf(1'b0, OAD_OFF_REGS, 0);
  endtask : dec
  // ==========================================================
  // scenarios
  task automatic t_flags;
    xf(1'b0, OAD_OFF_FLAGW, 0);
    `CHK(r, 32'h00000000)
    xf(1'b1, OAD_OFF_FLAGW, 32'hFFFFFFFF);
    xf(1'b0, OAD_OFF_FLAGW, 0);
    `CHK(r, {16'h0000, OAD_FLAG_MASK})
    xf(1'b0, 12'h040, 0);
    `CHK({e, r}, {1'b1, 32'h00000000})
  endtask : t_flags
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
      xf(1'b1, OAD_OFF_GPR_BASE + 12'(4 * i), {16'h0000, gv(i)});
    for (int i = 0; i < 8; i++)
    begin
      dec({16'h0000, 2'b11, 3'(i), 3'(i), 8'h89});
      `CHK(r, {gv(i), gv(i)})
      `CHK(a[15:0], 16'h0000)
      dec({16'h0000, 2'b11, 3'(i), 3'(i), 8'h88});
      `CHK(r[7:0], (i < 4) ? gv(i) & 16'h00FF : gv(i - 4) >> 8)
    end
  endtask : t_regs
  task automatic t_ea;
    logic [15:0] b, d;
    for (int k = 0; k < 3; k++)
      for (int m = 0; m < 8; m++)
      begin
        b = (m == 4 || m == 0 || m == 2) ? gv(6) : (m == 5 || m == 1 || m == 3) ? gv(7) : 0;
        b += (m < 2 || m == 7) ? gv(3) : (m == 2 || m == 3 || m == 6) ? gv(5) : 16'h0000;
        d = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFF80 : 16'h0180;
        dec({8'h01, 8'h80, 2'(k), 3'b000, 3'(m), 8'h89});
        `CHK(a[15:0], (k == 0 && m == 6) ? 16'h0180 : b + d)
        `CHK(a[18:16], 3'((k == 0 && m == 6) ? 2 : k))
      end
  endtask : t_ea
  task automatic t_seg;
    for (int g = 0; g < 4; g++)
    begin
      dec({16'h0000, 2'b11, 1'b0, 2'(g), 3'b000, 8'h8E});
      `CHK({s[5], s[1:0]}, {g == 1, 2'(g)})
    end
    xf(1'b0, OAD_OFF_STAT, 0);
    `CHK(r[0], 1'b1)
  endtask : t_seg
  // enable low must stall the access; a mid-run reset clears the condition word
  task automatic t_hold;
    clk_en <= 1'b0;
    fork
      xf(1'b1, OAD_OFF_FLAGW, 32'h00000801);
      begin
        repeat (4) @(posedge clk_sys);
        `CHK(pready, 1'b0)
        clk_en <= 1'b1;
      end
    join
    xf(1'b0, OAD_OFF_FLAGW, 0);
    `CHK(r, 32'h00000801)
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    xf(1'b0, OAD_OFF_FLAGW, 0);
    `CHK(r, {16'h0000, OAD_FLAG_RESET})
  endtask : t_hold
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // ==========================================================
  // hang guard, then main sequence
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_flags();
    t_regs();
    t_ea();
    t_seg();
    t_hold();
    finish_test();
  end
endmodule : oad_top_test
`default_nettype wire
